// [hw/bus_mgmt_csr_mem.sv]
`timescale 1ns/1ns
module bus_mgmt_csr_mem (
  input  wire logic        clk_i,
  input  wire logic        load_i,
  input  wire logic [31:0] init_bw_i,
  input  wire logic [31:0] init_hi_i,
  input  wire logic [31:0] init_lo_i,
  input  wire logic        wr_en_i,
  input  wire logic [1:0]  wr_sel_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic [1:0]  rd_sel_i,
  output logic      [31:0] rd_data_o
);
  import node_cfg_pkg::*;

  logic [31:0] csr_ff [4];

  // ==========================================================================
  // Storage: a bus reset reloads all four words and wins over a swap write.
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      csr_ff[0] <= BUS_OWNER_RESET;
      csr_ff[1] <= init_bw_i;
      csr_ff[2] <= init_hi_i;
      csr_ff[3] <= init_lo_i;
    end else if (wr_en_i) begin
      csr_ff[wr_sel_i] <= wr_data_i;
    end
  end

  // Registered read port.
  always_ff @(posedge clk_i) begin
    rd_data_o <= csr_ff[rd_sel_i];
  end

endmodule

// [hw/node_cfg_pkg.sv]
package node_cfg_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [11:0] OFS_UID_ROM_PORT   = 12'h004;
  localparam logic [11:0] OFS_RETRY_LIMITS   = 12'h008;
  localparam logic [11:0] OFS_SWAP_DATA      = 12'h00c;
  localparam logic [11:0] OFS_SWAP_COMPARE   = 12'h010;
  localparam logic [11:0] OFS_SWAP_CONTROL   = 12'h014;
  localparam logic [11:0] OFS_ROM_HEADER     = 12'h018;
  localparam logic [11:0] OFS_BUS_NAME       = 12'h01c;
  localparam logic [11:0] OFS_BUS_OPTIONS    = 12'h020;
  localparam logic [11:0] OFS_UID_UPPER      = 12'h024;
  localparam logic [11:0] OFS_UID_LOWER      = 12'h028;
  localparam logic [11:0] OFS_HOST_CONTROL   = 12'h050;
  localparam logic [11:0] OFS_INIT_BANDWIDTH = 12'h0b0;
  localparam logic [11:0] OFS_INIT_CHAN_HI   = 12'h0b4;
  localparam logic [11:0] OFS_INIT_CHAN_LO   = 12'h0b8;

  // ==========================================================================
  // Field positions.
  localparam int RETRY_PHY_LSB    = 8;
  localparam int RETRY_RESP_LSB   = 4;
  localparam int RETRY_REQ_LSB    = 0;
  localparam int SWAP_DONE_BIT    = 31;
  localparam int MAX_REC_LSB      = 12;
  localparam int LINK_ON_BIT      = 17;
  localparam int SOFT_RESTART_BIT = 16;

  // ==========================================================================
  // Constant and reset values.
  localparam logic [31:0] BUS_NAME_VALUE      = 32'h3133_3934;
  localparam logic [31:0] BUS_OWNER_RESET     = 32'h0000_003f;
  localparam logic [2:0]  LINK_SPEED_S400     = 3'h2;
  localparam logic [3:0]  MAX_REC_512_BYTES   = 4'h8;
  localparam logic [31:0] ROM_HEADER_RESET    = 32'h0000_0000;
  localparam logic [11:0] RETRY_RESET         = 12'h000;
  localparam int          SOFT_RESTART_CYCLES = 4;

  // ==========================================================================
  // Packet classes for the retry counter.
  typedef enum logic [1:0] {
    CLASS_REQUEST  = 2'h0,
    CLASS_RESPONSE = 2'h1,
    CLASS_PHY_RESP = 2'h2
  } pkt_class_t;

endpackage

// [hw/serial_bus_node_config_regs.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - Unique-ID ROM port reads all zero.
// - Busy or data-error acks retransmit up to limit.
// - Dual-phase retry fields read zero.
// - Three writable four-bit retry counts per class.
// - Data, compare, then selector write starts swap.
// - Completion flag set; data holds old value.
// - Selector picks owner, bandwidth, channels hi, lo.
// - Bus reset loads 3Fh and initial values.
// - Completion flag resets to one, device-updated.
// - ROM header fields writable, reset to zero.
// - Software reset keeps the ROM header.
// - Bus name register reads constant 3133_3934h.
// - Payload limit applies only while link enabled.
// - Payload limit 512 bytes after hardware reset.
// - Link speed field reads S400 code.
// - Unique-ID upper loaded from EEPROM after reset.
// - Software reset keeps the unique-ID registers.
// - Unique-ID lower writable, loaded from EEPROM.
// - Host control bit 17 enables the link.
// - Bit 16 starts soft reset, reads busy.
module serial_bus_node_config_regs #(
  parameter int SOFT_CYCLES = node_cfg_pkg::SOFT_RESTART_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [11:0]              adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  input  wire logic                     bus_reset_i,
  input  wire logic                     link_disconnect_i,
  output logic                          link_enable_o,
  output logic [3:0]                    max_payload_o,
  input  wire logic                     tx_result_valid_i,
  input  wire node_cfg_pkg::pkt_class_t tx_class_i,
  input  wire logic                     tx_busy_or_error_i,
  output logic                          retransmit_o,
  output logic                          give_up_o,
  input  wire logic                     lock_req_i,
  input  wire logic [1:0]               lock_sel_i,
  input  wire logic [31:0]              lock_arg_i,
  input  wire logic [31:0]              lock_data_i,
  output logic                          lock_ack_o,
  output logic [31:0]                   lock_old_o,
  output logic                          eeprom_load_req_o,
  input  wire logic                     eeprom_valid_i,
  input  wire logic [31:0]              eeprom_upper_i,
  input  wire logic [31:0]              eeprom_lower_i
);
  import node_cfg_pkg::*;

  // Refuse a soft reset length that the eight-bit counter cannot hold.
  if (SOFT_CYCLES < 1 || SOFT_CYCLES > 255) begin : g_bad_cycles
    $error("SOFT_CYCLES must lie between 1 and 255.");
  end

  typedef enum {ST_IDLE, ST_FETCH, ST_COMPARE} swap_state_t;

  // ==========================================================================
  // Helper functions.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] retry_limit(input logic [11:0] lim, input pkt_class_t cls);
    logic [3:0] r;
    r = 4'h0;
    unique case (cls)
      CLASS_REQUEST:  r = lim[RETRY_REQ_LSB  +: 4];
      CLASS_RESPONSE: r = lim[RETRY_RESP_LSB +: 4];
      CLASS_PHY_RESP: r = lim[RETRY_PHY_LSB  +: 4];
      default:        r = 4'h0;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Register state.
  logic [11:0]  retry_ff;
  logic [31:0]  swap_new_value_ff;
  logic [31:0]  swap_expected_value_ff;
  logic         swap_complete_flag_ff;
  logic [1:0]   swap_target_select_ff;
  logic         sw_go_ff;
  logic [31:0]  rom_header_ff;
  logic [3:0]   max_rec_ff;
  logic [31:0]  uid_upper_ff;
  logic [31:0]  uid_lower_ff;
  logic [31:0]  init_bw_ff;
  logic [31:0]  init_hi_ff;
  logic [31:0]  init_lo_ff;
  logic         link_on_ff;
  logic         restart_busy_ff;
  logic [7:0]   restart_cnt_ff;
  logic [3:0]   attempt_ff;
  swap_state_t  state_ff;
  logic         owner_link_ff;
  logic [1:0]   op_sel_ff;
  logic [31:0]  op_arg_ff;
  logic [31:0]  op_new_ff;
  logic [31:0]  csr_rd_data;
  logic         csr_wr_en;
  logic         swap_finish;
  logic         req;
  logic         wr;
  logic [11:0]  wadr;

  assign req  = cyc_i & stb_i & ~ack_o;
  assign wr   = cyc_i & stb_i & we_i & ack_o; // Writes land at the edge that sees ack.
  assign wadr = {adr_i[11:2], 2'h0};

  // ==========================================================================
  // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Read data mux, registered alongside the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      unique case (wadr)
        OFS_UID_ROM_PORT:   dat_o <= 32'h0000_0000;
        OFS_RETRY_LIMITS:   dat_o <= {20'h00000, retry_ff};
        OFS_SWAP_DATA:      dat_o <= swap_new_value_ff;
        OFS_SWAP_COMPARE:   dat_o <= swap_expected_value_ff;
        OFS_SWAP_CONTROL:   dat_o <= {swap_complete_flag_ff, 29'h0, swap_target_select_ff};
        OFS_ROM_HEADER:     dat_o <= rom_header_ff;
        OFS_BUS_NAME:       dat_o <= BUS_NAME_VALUE;
        OFS_BUS_OPTIONS:    dat_o <= {16'h0000, max_rec_ff, 9'h000, LINK_SPEED_S400};
        OFS_UID_UPPER:      dat_o <= uid_upper_ff;
        OFS_UID_LOWER:      dat_o <= uid_lower_ff;
        OFS_HOST_CONTROL:   dat_o <= {14'h0000, link_on_ff, restart_busy_ff, 16'h0000};
        OFS_INIT_BANDWIDTH: dat_o <= init_bw_ff;
        OFS_INIT_CHAN_HI:   dat_o <= init_hi_ff;
        OFS_INIT_CHAN_LO:   dat_o <= init_lo_ff;
        default:            dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Retry limits: only the three counts are stored, upper fields stay zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retry_ff <= RETRY_RESET;
    end else if (wr && wadr == OFS_RETRY_LIMITS) begin
      retry_ff <= 12'(merge_bytes({20'h00000, retry_ff}, dat_i, sel_i));
    end
  end

  // Retry engine counts attempts of the packet in flight.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attempt_ff   <= 4'h0;
      retransmit_o <= 1'b0;
      give_up_o    <= 1'b0;
    end else begin
      retransmit_o <= 1'b0;
      give_up_o    <= 1'b0;
      if (tx_result_valid_i) begin
        if (tx_busy_or_error_i && attempt_ff < retry_limit(retry_ff, tx_class_i)) begin
          retransmit_o <= 1'b1;
          attempt_ff   <= attempt_ff + 4'h1;
        end else begin
          give_up_o  <= tx_busy_or_error_i;
          attempt_ff <= 4'h0;
        end
      end
    end
  end

  // ==========================================================================
  // Initial-value registers reloaded into the CSRs on bus reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_bw_ff <= 32'h0000_0000;
      init_hi_ff <= 32'h0000_0000;
      init_lo_ff <= 32'h0000_0000;
    end else if (wr) begin
      if (wadr == OFS_INIT_BANDWIDTH) init_bw_ff <= merge_bytes(init_bw_ff, dat_i, sel_i);
      if (wadr == OFS_INIT_CHAN_HI)   init_hi_ff <= merge_bytes(init_hi_ff, dat_i, sel_i);
      if (wadr == OFS_INIT_CHAN_LO)   init_lo_ff <= merge_bytes(init_lo_ff, dat_i, sel_i);
    end
  end

  // ==========================================================================
  // Swap operand registers; hardware return of the old value wins over software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swap_new_value_ff      <= 32'h0000_0000;
      swap_expected_value_ff <= 32'h0000_0000;
    end else begin
      if (swap_finish && !owner_link_ff) begin
        swap_new_value_ff <= csr_rd_data;
      end else if (wr && wadr == OFS_SWAP_DATA) begin
        swap_new_value_ff <= merge_bytes(swap_new_value_ff, dat_i, sel_i);
      end
      if (wr && wadr == OFS_SWAP_COMPARE) begin
        swap_expected_value_ff <= merge_bytes(swap_expected_value_ff, dat_i, sel_i);
      end
    end
  end

  // Selector write starts a swap and clears the flag; completion sets it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swap_complete_flag_ff <= 1'b1;
      swap_target_select_ff <= 2'h0;
      sw_go_ff              <= 1'b0;
    end else begin
      if (wr && wadr == OFS_SWAP_CONTROL && sel_i[0]) begin
        swap_target_select_ff <= dat_i[1:0];
        sw_go_ff              <= 1'b1;
      end else if (state_ff == ST_IDLE && sw_go_ff) begin
        sw_go_ff <= 1'b0;
      end
      if (swap_finish && !owner_link_ff) begin
        swap_complete_flag_ff <= 1'b1;
      end else if (wr && wadr == OFS_SWAP_CONTROL && sel_i[0]) begin
        swap_complete_flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // One engine serves software and link lock requests in turn.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff      <= ST_IDLE;
      owner_link_ff <= 1'b0;
      op_sel_ff     <= 2'h0;
      op_arg_ff     <= 32'h0000_0000;
      op_new_ff     <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (sw_go_ff) begin
            owner_link_ff <= 1'b0;
            op_sel_ff     <= swap_target_select_ff;
            op_arg_ff     <= swap_expected_value_ff;
            op_new_ff     <= swap_new_value_ff;
            state_ff      <= ST_FETCH;
          end else if (lock_req_i && !lock_ack_o) begin
            owner_link_ff <= 1'b1;
            op_sel_ff     <= lock_sel_i;
            op_arg_ff     <= lock_arg_i;
            op_new_ff     <= lock_data_i;
            state_ff      <= ST_FETCH;
          end
        end
        ST_FETCH:   state_ff <= ST_COMPARE;
        ST_COMPARE: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign swap_finish = state_ff == ST_COMPARE;
  assign csr_wr_en   = swap_finish && csr_rd_data == op_arg_ff;

  // Link lock answer carries the old value for one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_ack_o <= 1'b0;
      lock_old_o <= 32'h0000_0000;
    end else begin
      lock_ack_o <= swap_finish && owner_link_ff;
      if (swap_finish && owner_link_ff) begin
        lock_old_o <= csr_rd_data;
      end
    end
  end

  bus_mgmt_csr_mem u_csr_mem (
    .clk_i     (clk_i),
    .load_i    (bus_reset_i),
    .init_bw_i (init_bw_ff),
    .init_hi_i (init_hi_ff),
    .init_lo_i (init_lo_ff),
    .wr_en_i   (csr_wr_en),
    .wr_sel_i  (op_sel_ff),
    .wr_data_i (op_new_ff),
    .rd_sel_i  (op_sel_ff),
    .rd_data_o (csr_rd_data)
  );

  // ==========================================================================
  // ROM header and payload limit survive a software reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rom_header_ff <= ROM_HEADER_RESET;
      max_rec_ff    <= MAX_REC_512_BYTES;
    end else if (wr) begin
      if (wadr == OFS_ROM_HEADER) begin
        rom_header_ff <= merge_bytes(rom_header_ff, dat_i, sel_i);
      end
      if (wadr == OFS_BUS_OPTIONS && sel_i[1]) begin
        max_rec_ff <= dat_i[MAX_REC_LSB +: 4];
      end
    end
  end

  // Effective payload limit is zero while the link is off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_payload_o <= 4'h0;
    end else begin
      max_payload_o <= link_on_ff ? max_rec_ff : 4'h0;
    end
  end

  // ==========================================================================
  // Unique ID: requested after hardware reset, loaded once, writable after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eeprom_load_req_o <= 1'b1;
      uid_upper_ff      <= 32'h0000_0000;
      uid_lower_ff      <= 32'h0000_0000;
    end else if (eeprom_load_req_o && eeprom_valid_i) begin
      eeprom_load_req_o <= 1'b0;
      uid_upper_ff      <= eeprom_upper_i;
      uid_lower_ff      <= eeprom_lower_i;
    end else if (wr) begin
      if (wadr == OFS_UID_UPPER) uid_upper_ff <= merge_bytes(uid_upper_ff, dat_i, sel_i);
      if (wadr == OFS_UID_LOWER) uid_lower_ff <= merge_bytes(uid_lower_ff, dat_i, sel_i);
    end
  end

  // ==========================================================================
  // Host control: link enable and the soft reset sequence.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_busy_ff <= 1'b1;
      restart_cnt_ff  <= 8'(SOFT_CYCLES);
    end else if (wr && wadr == OFS_HOST_CONTROL && sel_i[2] && dat_i[SOFT_RESTART_BIT]) begin
      restart_busy_ff <= 1'b1;
      restart_cnt_ff  <= 8'(SOFT_CYCLES);
    end else if (restart_cnt_ff != 8'h00) begin
      restart_cnt_ff <= restart_cnt_ff - 8'h01;
    end else begin
      restart_busy_ff <= 1'b0;
    end
  end

  // Link enable; disconnect or soft reset turns it off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_on_ff <= 1'b0;
    end else if (link_disconnect_i || restart_busy_ff) begin
      link_on_ff <= 1'b0;
    end else if (wr && wadr == OFS_HOST_CONTROL && sel_i[2]) begin
      link_on_ff <= dat_i[LINK_ON_BIT];
    end
  end

  // Registered copy of the link enable for the outside.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_enable_o <= 1'b0;
    end else begin
      link_enable_o <= link_on_ff;
    end
  end

endmodule

// [tb/cfg_regs_chk.sv]
`timescale 1ns/1ns
// ==========================================================================
// Checker on the ports of the register bank.
module cfg_regs_chk
  import node_cfg_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        link_disconnect_i,
  input wire logic        link_enable_o,
  input wire logic [3:0]  max_payload_o,
  input wire logic        tx_result_valid_i,
  input wire logic        tx_busy_or_error_i,
  input wire logic        retransmit_o,
  input wire logic        give_up_o,
  input wire logic        lock_req_i,
  input wire logic        lock_ack_o,
  input wire logic        eeprom_load_req_o,
  input wire logic        eeprom_valid_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A read accepted at one word address.
  sequence rd_at(logic [11:0] a);
    cyc_i && stb_i && !we_i && !ack_o && adr_i[11:2] == a[11:2];
  endsequence
  // A lock request that has just been raised.
  sequence lock_start;
    $rose(lock_req_i) && !lock_ack_o;
  endsequence
  rom_zero_a: assert property (rd_at(OFS_UID_ROM_PORT) |=> ack_o && dat_o == 32'h0)
    else $error("rom port read not zero");
  name_const_a: assert property (rd_at(OFS_BUS_NAME) |=> dat_o == BUS_NAME_VALUE)
    else $error("bus name constant wrong");
  retry_upper_a: assert property (rd_at(OFS_RETRY_LIMITS) |=> dat_o[31:12] == 20'h0)
    else $error("retry upper bits not zero");
  speed_code_a: assert property (rd_at(OFS_BUS_OPTIONS) |=> dat_o[2:0] == 3'h2)
    else $error("link speed code wrong");
  payload_gate_a: assert property (!link_enable_o [*2] |-> max_payload_o == 4'h0)
    else $error("payload limit shown while link off");
  resend_cause_a: assert property ((retransmit_o || give_up_o) |->
    $past(tx_result_valid_i && tx_busy_or_error_i) && !(retransmit_o && give_up_o))
    else $error("retry outcome without busy result");
  lock_answer_a: assert property (lock_start |-> ##[1:40] lock_ack_o)
    else $error("lock request not answered");
  lock_pulse_a: assert property (lock_ack_o |=> !lock_ack_o)
    else $error("lock answer longer than one cycle");
  eeprom_once_a: assert property (eeprom_valid_i && eeprom_load_req_o |=> !eeprom_load_req_o [*2])
    else $error("eeprom request not dropped");
  disconnect_a: assert property (link_disconnect_i |-> ##[1:2] !link_enable_o)
    else $error("disconnect did not clear link");
endmodule

// [tb/serial_bus_node_config_regs_bench.sv]
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench for the node configuration register bank.
module serial_bus_node_config_regs_bench;
  import node_cfg_pkg::*;
  typedef struct {logic [31:0] val; logic [31:0] msk;} note_t;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [11:0] adr_i = 0;
  logic [3:0]  sel_i = 4'hf, max_payload_o, lim [3];
  logic [31:0] dat_i = 0, dat_o, lock_arg_i = 0, lock_data_i = 0, lock_old_o, r, up, lo;
  logic [31:0] eeprom_upper_i = 0, eeprom_lower_i = 0, seed = 32'h4c, init_v [4];
  logic        bus_reset_i = 0, link_disconnect_i = 0, link_enable_o, tx_result_valid_i = 0;
  logic        tx_busy_or_error_i = 0, retransmit_o, give_up_o, lock_req_i = 0, lock_ack_o;
  logic        eeprom_load_req_o, eeprom_valid_i = 0, tx_seen = 0;
  logic [1:0]  lock_sel_i = 0, retry_q [$];
  pkt_class_t  tx_class_i = CLASS_REQUEST;
  note_t       bus_q [$], nb;
  logic [31:0] lock_q [$];
  int          bad_count = 0, tests_run = 0, k, a;

  serial_bus_node_config_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bus_reset_i(bus_reset_i), .link_disconnect_i(link_disconnect_i), .link_enable_o(link_enable_o),
    .max_payload_o(max_payload_o), .tx_result_valid_i(tx_result_valid_i), .tx_class_i(tx_class_i),
    .tx_busy_or_error_i(tx_busy_or_error_i), .retransmit_o(retransmit_o), .give_up_o(give_up_o),
    .lock_req_i(lock_req_i), .lock_sel_i(lock_sel_i), .lock_arg_i(lock_arg_i),
    .lock_data_i(lock_data_i), .lock_ack_o(lock_ack_o), .lock_old_o(lock_old_o),
    .eeprom_load_req_o(eeprom_load_req_o), .eeprom_valid_i(eeprom_valid_i),
    .eeprom_upper_i(eeprom_upper_i), .eeprom_lower_i(eeprom_lower_i));

  // Free-running 100 MHz clock.
  initial forever #5 clk_i = ~clk_i;

  // Xorshift source of test values.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Masked comparison of one result.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e & m, g & m);
    end
  endtask

  // One classic bus cycle; a read notes its expected data for the monitor.
  task automatic wb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= w ? d : rnd();
    bus_q.push_back('{d, w ? 32'h0 : m});
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 100);
    if (ack_o !== 1'b1) bad_count++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // Software compare-and-swap, then a check of flag and returned old value.
  task automatic swap(input logic [1:0] s, input logic [31:0] c, input logic [31:0] d, input logic [31:0] e);
    wb(1, OFS_SWAP_DATA, d, 0);
    wb(1, OFS_SWAP_COMPARE, c, 0);
    wb(1, OFS_SWAP_CONTROL, {30'h0, s}, 0);
    repeat (8) @(posedge clk_i);
    wb(0, OFS_SWAP_CONTROL, {1'b1, 29'h0, s}, 32'h8000_0003);
    wb(0, OFS_SWAP_DATA, e, '1);
  endtask

  // A lock request from the serial side, held until answered.
  task automatic lock(input logic [1:0] s, input logic [31:0] c, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_i);
    lock_req_i <= 1'b1;
    lock_sel_i <= s;
    lock_arg_i <= c;
    lock_data_i <= d;
    lock_q.push_back(e);
    do @(posedge clk_i); while (lock_ack_o !== 1'b1 && ++n < 50);
    if (lock_ack_o !== 1'b1) bad_count++;
    lock_req_i <= 1'b0;
  endtask

  // One transmit result; the expected outcome is {retransmit, give up}.
  task automatic tx(input pkt_class_t c, input logic b, input logic [1:0] e);
    @(posedge clk_i);
    tx_result_valid_i <= 1'b1;
    tx_class_i <= c;
    tx_busy_or_error_i <= b;
    retry_q.push_back(e);
    @(posedge clk_i);
    tx_result_valid_i <= 1'b0;
  endtask

  // Monitor: each answer takes the oldest note of its kind.
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && bus_q.size() > 0) begin
      nb = bus_q.pop_front();
      if (nb.msk != 0) chk("read data", nb.val, dat_o, nb.msk);
    end
    if (lock_ack_o === 1'b1 && lock_q.size() > 0) chk("lock old value", lock_q.pop_front(), lock_old_o, '1);
    if (tx_seen) chk("retry outcome", {30'h0, retry_q.pop_front()}, {30'h0, retransmit_o, give_up_o}, 32'h3);
    tx_seen <= tx_result_valid_i;
  end

  // Verdict and end of run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, OFS_HOST_CONTROL, 32'h1 << SOFT_RESTART_BIT, 32'h1 << SOFT_RESTART_BIT);
    repeat (10) @(posedge clk_i);
    chk("eeprom request", 1, {31'h0, eeprom_load_req_o}, 1);
    wb(0, OFS_SWAP_CONTROL, 32'h8000_0000, 32'h8000_0000);
    wb(0, OFS_ROM_HEADER, ROM_HEADER_RESET, '1);
    wb(0, OFS_UID_ROM_PORT, 0, '1);
    wb(0, OFS_BUS_NAME, BUS_NAME_VALUE, '1);
    wb(0, OFS_BUS_OPTIONS, {16'h0, MAX_REC_512_BYTES, 9'h0, LINK_SPEED_S400}, 32'hf007);
    wb(0, 12'h0fc, 0, '1);
    $display("reset values done");
    up = rnd();
    lo = rnd();
    for (k = 0; k < 2; k++) begin
      @(posedge clk_i);
      eeprom_valid_i <= 1'b1;
      eeprom_upper_i <= k ? ~up : up;
      eeprom_lower_i <= k ? ~lo : lo;
      @(posedge clk_i);
      eeprom_valid_i <= 1'b0;
    end
    wb(0, OFS_UID_UPPER, up, '1);
    wb(0, OFS_UID_LOWER, lo, '1);
    r = rnd();
    wb(1, OFS_RETRY_LIMITS, '1, 0);
    wb(0, OFS_RETRY_LIMITS, 32'hfff, '1);
    wb(1, OFS_ROM_HEADER, r, 0);
    wb(0, OFS_ROM_HEADER, r, '1);
    wb(1, OFS_UID_LOWER, ~lo, 0);
    wb(0, OFS_UID_LOWER, ~lo, '1);
    wb(1, OFS_BUS_OPTIONS, 32'h5000, 0);
    $display("eeprom and writable fields done");
    wb(1, OFS_HOST_CONTROL, 32'h1 << SOFT_RESTART_BIT, 0);
    wb(0, OFS_HOST_CONTROL, 32'h1 << SOFT_RESTART_BIT, 32'h1 << SOFT_RESTART_BIT);
    repeat (10) @(posedge clk_i);
    wb(0, OFS_ROM_HEADER, r, '1);
    wb(0, OFS_UID_UPPER, up, '1);
    wb(0, OFS_UID_LOWER, ~lo, '1);
    wb(0, OFS_BUS_OPTIONS, 32'h5000, 32'hf000);
    $display("soft reset done");
    wb(1, OFS_HOST_CONTROL, 32'h1 << LINK_ON_BIT, 0);
    repeat (3) @(posedge clk_i);
    chk("link enable", 1, {31'h0, link_enable_o}, 1);
    chk("payload limit", 5, {28'h0, max_payload_o}, 32'hf);
    @(posedge clk_i);
    link_disconnect_i <= 1'b1;
    @(posedge clk_i);
    link_disconnect_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("link enable", 0, {31'h0, link_enable_o}, 1);
    chk("payload limit", 0, {28'h0, max_payload_o}, 32'hf);
    $display("link gating done");
    init_v[0] = BUS_OWNER_RESET;
    for (k = 1; k < 4; k++) begin
      init_v[k] = rnd();
      wb(1, OFS_INIT_BANDWIDTH + 12'(4 * (k - 1)), init_v[k], 0);
    end
    @(posedge clk_i);
    bus_reset_i <= 1'b1;
    @(posedge clk_i);
    bus_reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (k = 0; k < 4; k++) begin
      r = rnd();
      swap(2'(k), init_v[k], r, init_v[k]);
      init_v[k] = r;
    end
    swap(1, ~init_v[1], rnd(), init_v[1]);
    r = rnd();
    swap(1, init_v[1], r, init_v[1]);
    init_v[1] = r;
    r = rnd();
    lock(2, init_v[2], r, init_v[2]);
    swap(2, r, rnd(), r);
    $display("compare and swap done");
    for (k = 0; k < 3; k++) lim[k] = rnd() & 4'h3;
    wb(1, OFS_RETRY_LIMITS, {20'h0, lim[2], lim[1], lim[0]}, 0);
    wb(0, OFS_RETRY_LIMITS, {20'h0, lim[2], lim[1], lim[0]}, '1);
    for (k = 0; k < 3; k++) begin
      tx(pkt_class_t'(k), 1, lim[k] != 0 ? 2'b10 : 2'b01);
      tx(pkt_class_t'(k), 0, 2'b00);
      for (a = 0; a <= lim[k]; a++) tx(pkt_class_t'(k), 1, a < lim[k] ? 2'b10 : 2'b01);
    end
    repeat (3) @(posedge clk_i);
    $display("retry limits done");
    print_verdict();
  end
endmodule

bind serial_bus_node_config_regs cfg_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .link_disconnect_i(link_disconnect_i), .link_enable_o(link_enable_o), .max_payload_o(max_payload_o),
  .tx_result_valid_i(tx_result_valid_i), .tx_busy_or_error_i(tx_busy_or_error_i),
  .retransmit_o(retransmit_o), .give_up_o(give_up_o), .lock_req_i(lock_req_i), .lock_ack_o(lock_ack_o),
  .eeprom_load_req_o(eeprom_load_req_o), .eeprom_valid_i(eeprom_valid_i));
